// ==== include/power_state_pkg.sv ====
package power_state_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam int         PADDR_W           = 8;
  localparam logic [7:0] CTRL_OFFSET       = 8'h00;
  localparam logic [7:0] WD_LIMIT_OFFSET   = 8'h04;
  localparam logic [7:0] STATUS_OFFSET     = 8'h08;
  localparam logic [7:0] IRQ_STATUS_OFFSET = 8'h0c;
  localparam logic [7:0] IRQ_ENABLE_OFFSET = 8'h10;
  localparam logic [7:0] IRQ_CLEAR_OFFSET  = 8'h14;

  // control fields
  localparam int         CTRL_W            = 5;
  localparam int         CTRL_POL_INV_BIT  = 0;
  localparam int         CTRL_QUICK_OFF_BIT = 1;
  localparam int         CTRL_EDGE_MODE_BIT = 2;
  localparam int         CTRL_XFAIL_EN_BIT = 3;
  localparam int         CTRL_OVLO_DIS_BIT = 4;
  localparam logic [4:0] CTRL_RESET        = 5'h00;
  localparam int         WD_LIMIT_RESET    = 4;

  // status fields
  localparam int         STAT_STATE_LSB    = 0;
  localparam int         STAT_TRIM_BIT     = 4;
  localparam int         STAT_FUSE_BIT     = 5;
  localparam int         STAT_STEST_BIT    = 6;
  localparam int         STAT_WDCNT_LSB    = 8;

  // interrupt events
  localparam int         IRQ_W             = 5;
  localparam int         IRQ_STATE_BIT     = 0;
  localparam int         IRQ_WD_BIT        = 1;
  localparam int         IRQ_FAULT_BIT     = 2;
  localparam int         IRQ_STEST_BIT     = 3;
  localparam int         IRQ_LOAD_BIT      = 4;
  localparam logic [4:0] IRQ_RESET         = 5'h00;

  // synchronised pin indexes
  localparam int         PIN_W             = 7;
  localparam int         PIN_LOW_POWER     = 0;
  localparam int         PIN_TEST_BOARD    = 1;
  localparam int         PIN_POWER_ON      = 2;
  localparam int         PIN_EXT_FAIL      = 3;
  localparam int         PIN_VIN_UV        = 4;
  localparam int         PIN_VIN_OV        = 5;
  localparam int         PIN_TJ_TSD        = 6;

  // timing
  localparam int CLK_PERIOD_NS   = 20;
  localparam int WD_DELAY_US     = 30;
  localparam int WD_DELAY_CYCLES =
    (WD_DELAY_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WD_TIMER_W      = 11;

  typedef enum logic [3:0] {
    fuse_load_state,
    deep_off_state,
    self_test_state,
    fast_wake_off_state,
    power_up_state,
    run_state,
    standby_state,
    watchdog_reset_state,
    fault_power_down_state
  } state_t;

endpackage

// ==== core/power_state_transition_fsm.sv ====
// Added by the designer: register access over APB and the register offsets.
`timescale 1ns/1ps

module power_state_transition_fsm #(
  parameter int WD_COUNT_W     = 4,
  parameter bit SAFETY_VARIANT = 1'b1
) (
  // clock and reset
  input  wire logic                          pclk,
  input  wire logic                          presetn,
  // apb slave
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [7:0]                    paddr,
  input  wire logic [31:0]                   pwdata,
  output logic      [31:0]                   prdata,
  output logic                               pready,
  output logic                               pslverr,
  // control pins, asynchronous
  input  wire logic                          low_power_request_pin,
  input  wire logic                          test_board_pin,
  input  wire logic                          power_on_request_pin,
  input  wire logic                          external_fail_input,
  // analog comparators, asynchronous
  input  wire logic                          vin_above_undervoltage,
  input  wire logic                          vin_above_overvoltage,
  input  wire logic                          tj_above_thermal_shutdown,
  // same-clock events
  input  wire logic                          fuse_load_done,
  input  wire logic                          trim_crc_fail,
  input  wire logic                          fuse_crc_fail,
  input  wire logic                          self_test_done,
  input  wire logic                          self_test_pass,
  input  wire logic                          watchdog_hard_reset,
  input  wire logic                          power_up_done,
  input  wire logic                          power_down_done,
  // state and interrupt
  output power_state_pkg::state_t            state,
  output logic                               irq
);

  localparam int TW = power_state_pkg::WD_TIMER_W;
  localparam int W  = WD_COUNT_W;
  localparam logic [TW-1:0] WD_LOAD =
    TW'(power_state_pkg::WD_DELAY_CYCLES - 1);

  if (W < 1 || W > 8) begin : g_bad_count_w
    $error("watchdog count width must be 1 to 8");
  end
  if (power_state_pkg::WD_DELAY_CYCLES > (1 << TW)) begin : g_bad_timer
    $error("watchdog delay does not fit the timer");
  end

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [power_state_pkg::PIN_W-1:0] sync1;
  logic [power_state_pkg::PIN_W-1:0] sync2;
  logic                              power_on_prev;
  logic                              vin_uv_prev;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1         <= '0;
      sync2         <= '0;
      power_on_prev <= 1'b0;
      vin_uv_prev   <= 1'b0;
    end else begin
      sync1 <= {tj_above_thermal_shutdown, vin_above_overvoltage,
                vin_above_undervoltage, external_fail_input,
                power_on_request_pin, test_board_pin,
                low_power_request_pin};
      sync2         <= sync1;
      power_on_prev <= sync2[power_state_pkg::PIN_POWER_ON];
      vin_uv_prev   <= sync2[power_state_pkg::PIN_VIN_UV];
    end
  end

  // ----------------------------------------------------------------
  // transition qualifiers
  // ----------------------------------------------------------------
  logic [power_state_pkg::CTRL_W-1:0] ctrl;
  logic [W-1:0]                       wd_limit;
  logic                               trim_load_error;
  logic                               fuse_config_load_error;
  logic                               self_test_failed;
  logic [W-1:0]                       watchdog_event_count;
  logic [TW-1:0]                      wd_timer;

  logic test_board;
  logic quick_off_select;
  logic standby_request;
  logic power_request;
  logic env_ok;
  logic load_ok;
  logic xfail_ok;
  logic valid_power_up;
  logic fast_wake_ok;
  logic vin_detect;

  assign test_board       = sync2[power_state_pkg::PIN_TEST_BOARD];
  assign quick_off_select = ctrl[power_state_pkg::CTRL_QUICK_OFF_BIT];
  assign standby_request  = sync2[power_state_pkg::PIN_LOW_POWER] ^
                            ctrl[power_state_pkg::CTRL_POL_INV_BIT];
  // level when edge mode is 0, high-to-low edge when it is 1
  assign power_request    = ctrl[power_state_pkg::CTRL_EDGE_MODE_BIT] ?
    (power_on_prev & ~sync2[power_state_pkg::PIN_POWER_ON]) :
    sync2[power_state_pkg::PIN_POWER_ON];
  assign env_ok = sync2[power_state_pkg::PIN_VIN_UV] &
    (ctrl[power_state_pkg::CTRL_OVLO_DIS_BIT] |
     ~sync2[power_state_pkg::PIN_VIN_OV]) &
    ~sync2[power_state_pkg::PIN_TJ_TSD];
  assign load_ok        = ~trim_load_error & ~fuse_config_load_error;
  assign xfail_ok       = ~ctrl[power_state_pkg::CTRL_XFAIL_EN_BIT] |
                          sync2[power_state_pkg::PIN_EXT_FAIL];
  assign valid_power_up = power_request & env_ok & load_ok;
  assign fast_wake_ok   = load_ok & ~self_test_failed & xfail_ok;
  assign vin_detect     = sync2[power_state_pkg::PIN_VIN_UV] &
                          ~vin_uv_prev;

  // ----------------------------------------------------------------
  // state machine
  // ----------------------------------------------------------------
  power_state_pkg::state_t     next_state;
  logic                        next_trim_err;
  logic                        next_fuse_err;
  logic                        next_stest_err;
  logic [W-1:0]                next_wd_count;
  logic [TW-1:0]               next_wd_timer;
  logic [power_state_pkg::IRQ_W-1:0] events;
  power_state_pkg::state_t     off_exit;

  always_comb begin
    next_state     = state;
    next_trim_err  = trim_load_error;
    next_fuse_err  = fuse_config_load_error;
    next_stest_err = self_test_failed;
    next_wd_count  = watchdog_event_count;
    next_wd_timer  = wd_timer;
    events         = '0;
    off_exit       = SAFETY_VARIANT ? power_state_pkg::self_test_state :
                     power_state_pkg::fast_wake_off_state;
    case (state)
      power_state_pkg::fuse_load_state: begin
        if (fuse_load_done) begin
          next_trim_err = trim_crc_fail;
          next_fuse_err = fuse_crc_fail;
          events[power_state_pkg::IRQ_LOAD_BIT] =
            trim_crc_fail | fuse_crc_fail;
          if (!trim_crc_fail && !fuse_crc_fail) begin
            next_state = power_state_pkg::deep_off_state;
          end
        end
      end
      power_state_pkg::deep_off_state: begin
        if (test_board) begin
          next_state = off_exit;
        end else if (quick_off_select) begin
          next_state = off_exit;
        end else if (valid_power_up) begin
          next_state = off_exit;
        end
      end
      power_state_pkg::self_test_state: begin
        if (self_test_done && !self_test_pass) begin
          next_stest_err = 1'b1;
          events[power_state_pkg::IRQ_STEST_BIT] = 1'b1;
        end
        if (test_board || (self_test_done && self_test_pass)) begin
          next_state = power_state_pkg::fast_wake_off_state;
        end
      end
      power_state_pkg::fast_wake_off_state: begin
        if (!quick_off_select && !test_board) begin
          if (fast_wake_ok) begin
            next_state = power_state_pkg::power_up_state;
          end
        end else if (valid_power_up && fast_wake_ok) begin
          next_state = power_state_pkg::power_up_state;
        end
      end
      power_state_pkg::power_up_state: begin
        if (power_up_done) begin
          next_state = power_state_pkg::run_state;
        end
      end
      power_state_pkg::run_state,
      power_state_pkg::standby_state: begin
        if (watchdog_hard_reset) begin
          next_state    = power_state_pkg::watchdog_reset_state;
          next_wd_timer = WD_LOAD;
          if (watchdog_event_count != {W{1'b1}}) begin
            next_wd_count = watchdog_event_count + 1'b1;
          end
          events[power_state_pkg::IRQ_WD_BIT] = 1'b1;
        end else if (state == power_state_pkg::run_state) begin
          if (standby_request) begin
            next_state = power_state_pkg::standby_state;
          end
        end else if (!standby_request) begin
          next_state = power_state_pkg::run_state;
        end
      end
      power_state_pkg::watchdog_reset_state: begin
        if (watchdog_event_count >= wd_limit) begin
          next_state = power_state_pkg::fault_power_down_state;
          events[power_state_pkg::IRQ_FAULT_BIT] = 1'b1;
        end else if (wd_timer == '0) begin
          next_state = power_state_pkg::run_state;
        end else begin
          next_wd_timer = wd_timer - 1'b1;
        end
      end
      power_state_pkg::fault_power_down_state: begin
        if (power_down_done) begin
          next_state    = power_state_pkg::deep_off_state;
          next_wd_count = '0;
        end
      end
      default: begin
        next_state = power_state_pkg::fuse_load_state;
      end
    endcase
    events[power_state_pkg::IRQ_STATE_BIT] = (next_state != state);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state                  <= power_state_pkg::fuse_load_state;
      trim_load_error        <= 1'b0;
      fuse_config_load_error <= 1'b0;
      self_test_failed       <= 1'b0;
      watchdog_event_count   <= '0;
      wd_timer               <= '0;
    end else begin
      state                  <= next_state;
      trim_load_error        <= next_trim_err;
      fuse_config_load_error <= next_fuse_err;
      self_test_failed       <= next_stest_err;
      watchdog_event_count   <= next_wd_count;
      wd_timer               <= next_wd_timer;
    end
  end

  // ----------------------------------------------------------------
  // apb registers and interrupt
  // ----------------------------------------------------------------
  logic [power_state_pkg::IRQ_W-1:0]  irq_status;
  logic [power_state_pkg::IRQ_W-1:0]  irq_enable;
  logic [power_state_pkg::CTRL_W-1:0] next_ctrl;
  logic [W-1:0]                       next_wd_limit;
  logic [power_state_pkg::IRQ_W-1:0]  next_irq_status;
  logic [power_state_pkg::IRQ_W-1:0]  next_irq_enable;
  logic [power_state_pkg::IRQ_W-1:0]  irq_clear;
  logic                               next_irq;
  logic [31:0]                        next_prdata;
  logic                               next_pready;
  logic                               next_pslverr;
  logic                               wr_done;

  function automatic logic addr_mapped(input logic [7:0] a);
    return a == power_state_pkg::CTRL_OFFSET ||
           a == power_state_pkg::WD_LIMIT_OFFSET ||
           a == power_state_pkg::STATUS_OFFSET ||
           a == power_state_pkg::IRQ_STATUS_OFFSET ||
           a == power_state_pkg::IRQ_ENABLE_OFFSET ||
           a == power_state_pkg::IRQ_CLEAR_OFFSET;
  endfunction

  always_comb begin
    next_ctrl       = ctrl;
    next_wd_limit   = wd_limit;
    next_irq_enable = irq_enable;
    irq_clear       = '0;
    next_prdata     = prdata;
    next_pslverr    = pslverr;
    next_pready     = psel & penable & ~pready;
    wr_done = psel & penable & pready & pwrite & addr_mapped(paddr);
    if (next_pready) begin
      next_prdata  = '0;
      next_pslverr = ~addr_mapped(paddr);
      case (paddr)
        power_state_pkg::CTRL_OFFSET: begin
          next_prdata[power_state_pkg::CTRL_W-1:0] = ctrl;
        end
        power_state_pkg::WD_LIMIT_OFFSET: begin
          next_prdata[W-1:0] = wd_limit;
        end
        power_state_pkg::STATUS_OFFSET: begin
          next_prdata[power_state_pkg::STAT_STATE_LSB +: 4] = 4'(state);
          next_prdata[power_state_pkg::STAT_TRIM_BIT] = trim_load_error;
          next_prdata[power_state_pkg::STAT_FUSE_BIT] =
            fuse_config_load_error;
          next_prdata[power_state_pkg::STAT_STEST_BIT] = self_test_failed;
          next_prdata[power_state_pkg::STAT_WDCNT_LSB +: W] =
            watchdog_event_count;
        end
        power_state_pkg::IRQ_STATUS_OFFSET: begin
          next_prdata[power_state_pkg::IRQ_W-1:0] = irq_status;
        end
        power_state_pkg::IRQ_ENABLE_OFFSET: begin
          next_prdata[power_state_pkg::IRQ_W-1:0] = irq_enable;
        end
        default: begin
          next_prdata = '0;
        end
      endcase
    end
    if (wr_done) begin
      case (paddr)
        power_state_pkg::CTRL_OFFSET: begin
          next_ctrl = pwdata[power_state_pkg::CTRL_W-1:0];
        end
        power_state_pkg::WD_LIMIT_OFFSET: begin
          next_wd_limit = pwdata[W-1:0];
        end
        power_state_pkg::IRQ_ENABLE_OFFSET: begin
          next_irq_enable = pwdata[power_state_pkg::IRQ_W-1:0];
        end
        power_state_pkg::IRQ_CLEAR_OFFSET: begin
          irq_clear = pwdata[power_state_pkg::IRQ_W-1:0];
        end
        default: begin
          next_ctrl = ctrl;
        end
      endcase
    end
    // voltage detection overrides a same-cycle software write
    if (vin_detect) begin
      next_ctrl[power_state_pkg::CTRL_QUICK_OFF_BIT] = 1'b0;
    end
    // a new event wins over a same-cycle clear
    next_irq_status = (irq_status & ~irq_clear) | events;
    next_irq        = |(next_irq_status & next_irq_enable);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl       <= power_state_pkg::CTRL_RESET;
      wd_limit   <= W'(power_state_pkg::WD_LIMIT_RESET);
      irq_status <= power_state_pkg::IRQ_RESET;
      irq_enable <= power_state_pkg::IRQ_RESET;
      irq        <= 1'b0;
      prdata     <= 32'h0000_0000;
      pready     <= 1'b0;
      pslverr    <= 1'b0;
    end else begin
      ctrl       <= next_ctrl;
      wd_limit   <= next_wd_limit;
      irq_status <= next_irq_status;
      irq_enable <= next_irq_enable;
      irq        <= next_irq;
      prdata     <= next_prdata;
      pready     <= next_pready;
      pslverr    <= next_pslverr;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  logic [15:0] wd_dwell;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wd_dwell <= '0;
    end else if (state == power_state_pkg::watchdog_reset_state) begin
      wd_dwell <= wd_dwell + 1'b1;
    end else begin
      wd_dwell <= '0;
    end
  end

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  run_to_standby_a: assert property (
    state == power_state_pkg::run_state && !watchdog_hard_reset &&
    standby_request |=> state == power_state_pkg::standby_state)
    else $error("run did not enter standby");

  standby_to_run_a: assert property (
    state == power_state_pkg::standby_state && !watchdog_hard_reset &&
    !standby_request |=> state == power_state_pkg::run_state)
    else $error("standby did not return to run");

  wd_entry_a: assert property (
    (state == power_state_pkg::run_state ||
     state == power_state_pkg::standby_state) && watchdog_hard_reset
    |=> state == power_state_pkg::watchdog_reset_state)
    else $error("watchdog reset not entered");

  wd_delay_a: assert property (
    state == power_state_pkg::watchdog_reset_state ##1
    state == power_state_pkg::run_state
    |-> $past(wd_dwell) == 16'(power_state_pkg::WD_DELAY_CYCLES - 1))
    else $error("watchdog delay length wrong");

  wd_limit_a: assert property (
    state == power_state_pkg::watchdog_reset_state &&
    watchdog_event_count == wd_limit
    |=> state == power_state_pkg::fault_power_down_state)
    else $error("watchdog limit did not fault");

  load_gate_a: assert property (
    state == power_state_pkg::fuse_load_state ##1
    state == power_state_pkg::deep_off_state
    |-> !trim_load_error && !fuse_config_load_error)
    else $error("deep-off entered with load error");

  quick_off_clear_a: assert property (
    vin_detect |=> !quick_off_select)
    else $error("quick-off select not cleared");

  deep_off_exit_a: assert property (
    state == power_state_pkg::deep_off_state ##1
    state != power_state_pkg::deep_off_state
    |-> $past(test_board || quick_off_select || valid_power_up))
    else $error("deep-off left without cause");

  power_up_gate_a: assert property (
    state == power_state_pkg::fast_wake_off_state ##1
    state == power_state_pkg::power_up_state |-> $past(fast_wake_ok))
    else $error("power-up started with blocked start");

  self_test_exit_a: assert property (
    state == power_state_pkg::self_test_state ##1
    state == power_state_pkg::fast_wake_off_state
    |-> $past(test_board || (self_test_done && self_test_pass)))
    else $error("self-test left without pass");

  irq_level_a: assert property (
    ##1 irq == |($past(next_irq_status) & $past(next_irq_enable)))
    else $error("interrupt level wrong");

endmodule

// ==== verification/host_pins_model.sv ====
`timescale 1ns/1ps
module host_pins_model (
  // bench side
  input  wire logic pclk,
  input  wire logic want_on,
  input  wire logic edge_mode,
  input  wire logic permit,
  // pins
  output logic      power_on_request_pin,
  output logic      external_fail_input
);
  // edge mode idles high and steps low to request
  always_ff @(posedge pclk) begin
    power_on_request_pin <= want_on ^ edge_mode;
    external_fail_input  <= permit;
  end
endmodule

// ==== verification/power_state_transition_fsm_tb_top.sv ====
`timescale 1ns/1ps
module power_state_transition_fsm_tb_top;
  // --------
  // signals
  // --------
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic        pwrite = 1'b0, pready, pslverr, er, irq, want_on = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
  logic        low_power_request_pin = 1'b0, test_board_pin = 1'b0;
  logic        power_on_request_pin, external_fail_input;
  logic        edge_mode = 1'b0, permit = 1'b1;
  logic        vin_above_undervoltage = 1'b1, vin_above_overvoltage = 1'b0;
  logic        tj_above_thermal_shutdown = 1'b0, fuse_load_done = 1'b0;
  logic        trim_crc_fail = 1'b0, fuse_crc_fail = 1'b0;
  logic        self_test_done = 1'b0, self_test_pass = 1'b0;
  logic        watchdog_hard_reset = 1'b0, power_up_done = 1'b0;
  logic        power_down_done = 1'b0;
  power_state_pkg::state_t state;
  int          n_mismatch = 0, num_checks = 0, cyc = 0;

  always #10 pclk = ~pclk;

  host_pins_model host_pins_model_inst (
    .pclk(pclk), .want_on(want_on), .edge_mode(edge_mode), .permit(permit),
    .power_on_request_pin(power_on_request_pin),
    .external_fail_input(external_fail_input));

  power_state_transition_fsm power_state_transition_fsm_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr),
    .low_power_request_pin(low_power_request_pin),
    .test_board_pin(test_board_pin),
    .power_on_request_pin(power_on_request_pin),
    .external_fail_input(external_fail_input),
    .vin_above_undervoltage(vin_above_undervoltage),
    .vin_above_overvoltage(vin_above_overvoltage),
    .tj_above_thermal_shutdown(tj_above_thermal_shutdown),
    .fuse_load_done(fuse_load_done), .trim_crc_fail(trim_crc_fail),
    .fuse_crc_fail(fuse_crc_fail), .self_test_done(self_test_done),
    .self_test_pass(self_test_pass),
    .watchdog_hard_reset(watchdog_hard_reset),
    .power_up_done(power_up_done), .power_down_done(power_down_done),
    .state(state), .irq(irq));

  // --------
  // scenarios
  // --------
  task automatic chk(input string nm, input logic [31:0] got, exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic finish_test();
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wait_st(input power_state_pkg::state_t s, input int lim);
    for (int n = 0; state !== s && n < lim; n++) @(posedge pclk);
    chk(s.name(), {28'h000_0000, state}, {28'h000_0000, s});
  endtask

  task automatic hard_wd();
    watchdog_hard_reset <= 1'b1;
    @(posedge pclk);
    watchdog_hard_reset <= 1'b0;
    wait_st(power_state_pkg::watchdog_reset_state, 3);
  endtask

  task automatic t_boot();
    apb(1'b0, power_state_pkg::CTRL_OFFSET, 32'h0000_0000);
    chk("ctrl", rd, 32'h0000_0000);
    apb(1'b0, power_state_pkg::WD_LIMIT_OFFSET, 32'h0000_0000);
    chk("wd_limit", rd, 32'h0000_0004);
    apb(1'b0, 8'h40, 32'h0000_0000);
    chk("unmapped", {31'h0, er}, 32'h0000_0001);
    fuse_load_done <= 1'b1;
    @(posedge pclk);
    fuse_load_done <= 1'b0;
    repeat (20) @(posedge pclk);
    wait_st(power_state_pkg::deep_off_state, 0);
  endtask

  task automatic t_start();
    tj_above_thermal_shutdown <= 1'b1;
    want_on <= 1'b1;
    repeat (10) @(posedge pclk);
    wait_st(power_state_pkg::deep_off_state, 0);
    tj_above_thermal_shutdown <= 1'b0;
    wait_st(power_state_pkg::self_test_state, 8);
    self_test_pass <= 1'b1;
    self_test_done <= 1'b1;
    @(posedge pclk);
    self_test_done <= 1'b0;
    wait_st(power_state_pkg::fast_wake_off_state, 4);
    wait_st(power_state_pkg::power_up_state, 4);
    power_up_done <= 1'b1;
    wait_st(power_state_pkg::run_state, 4);
    power_up_done <= 1'b0;
  endtask

  task automatic t_standby();
    for (int i = 0; i < 2; i++) begin
      apb(1'b1, power_state_pkg::CTRL_OFFSET, {31'h0, i[0]});
      low_power_request_pin <= !i[0];
      wait_st(power_state_pkg::standby_state, 6);
      low_power_request_pin <= i[0];
      wait_st(power_state_pkg::run_state, 6);
    end
  endtask

  task automatic t_watchdog();
    int n;
    apb(1'b1, power_state_pkg::IRQ_ENABLE_OFFSET, 32'h0000_0002);
    hard_wd();
    for (n = 0; state !== power_state_pkg::run_state && n < 1600; n++)
      @(posedge pclk);
    chk("wd_delay", {31'h0, n >= 1499 && n <= 1500}, 32'h0000_0001);
    chk("irq", {31'h0, irq}, 32'h0000_0001);
    apb(1'b0, power_state_pkg::IRQ_STATUS_OFFSET, 32'h0000_0000);
    chk("irq_status", rd & 32'h0000_0002, 32'h0000_0002);
    apb(1'b1, power_state_pkg::IRQ_CLEAR_OFFSET, 32'h0000_0002);
    apb(1'b1, power_state_pkg::IRQ_ENABLE_OFFSET, 32'h0000_0000);
    apb(1'b1, power_state_pkg::WD_LIMIT_OFFSET, 32'h0000_0002);
    chk("irq_cleared", {31'h0, irq}, 32'h0000_0000);
    hard_wd();
    wait_st(power_state_pkg::fault_power_down_state, 4);
    chk("irq_masked", {31'h0, irq}, 32'h0000_0000);
  endtask

  task automatic t_quick();
    low_power_request_pin <= 1'b0;
    want_on               <= 1'b0;
    edge_mode             <= 1'b1;
    permit                <= 1'b0;
    apb(1'b1, power_state_pkg::WD_LIMIT_OFFSET, 32'h0000_0001);
    apb(1'b1, power_state_pkg::CTRL_OFFSET, 32'h0000_000e);
    for (int i = 0; i < 2; i++) begin
      power_down_done <= 1'b1;
      wait_st(power_state_pkg::deep_off_state, 4);
      power_down_done <= 1'b0;
      wait_st(power_state_pkg::self_test_state, 4);
      self_test_done <= !i[0];
      wait_st(power_state_pkg::fast_wake_off_state, 4);
      self_test_done <= 1'b0;
      want_on        <= 1'b1;
      repeat (8) @(posedge pclk);
      wait_st(power_state_pkg::fast_wake_off_state, 0);
      want_on <= 1'b0;
      permit  <= 1'b1;
      repeat (6) @(posedge pclk);
      want_on <= 1'b1;
      wait_st(power_state_pkg::power_up_state, 8);
      power_up_done <= 1'b1;
      wait_st(power_state_pkg::run_state, 4);
      power_up_done <= 1'b0;
      apb(1'b1, power_state_pkg::CTRL_OFFSET, 32'h0000_000c);
      test_board_pin <= 1'b1;
      hard_wd();
      wait_st(power_state_pkg::fault_power_down_state, 4);
    end
  endtask

  task automatic t_load();
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn        <= 1'b1;
    trim_crc_fail  <= 1'b1;
    fuse_load_done <= 1'b1;
    @(posedge pclk);
    trim_crc_fail  <= 1'b0;
    fuse_load_done <= 1'b0;
    repeat (4) @(posedge pclk);
    wait_st(power_state_pkg::fuse_load_state, 0);
    apb(1'b0, power_state_pkg::STATUS_OFFSET, 32'h0000_0000);
    chk("status", rd, 32'h0000_0010);
  endtask

  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_boot();
    t_start();
    t_standby();
    t_watchdog();
    t_quick();
    t_load();
    finish_test();
  end

  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      finish_test();
    end
  end
endmodule
